// *** include/spp_pkg.sv ***
package spp_pkg;

  // port geometry
  localparam int unsigned SPP_PINS = 6;
  localparam int unsigned SPP_PL_PINS = 4;
  localparam int unsigned SPP_ADDR_W = 5;
  localparam int unsigned SPP_DUTY_W = 10;

  // register offsets
  localparam logic [4:0] SPP_A_PORT_DATA = 5'h00;
  localparam logic [4:0] SPP_A_DIR = 5'h01;
  localparam logic [4:0] SPP_A_PULL_HIGH = 5'h02;
  localparam logic [4:0] SPP_A_PULL_LOW = 5'h03;
  localparam logic [4:0] SPP_A_OPEN_DRAIN = 5'h04;
  localparam logic [4:0] SPP_A_CHG_SEL = 5'h05;
  localparam logic [4:0] SPP_A_IRQ_FLAG = 5'h06;
  localparam logic [4:0] SPP_A_IRQ_EN = 5'h07;
  localparam logic [4:0] SPP_A_IRQ_EDGE = 5'h08;
  localparam logic [4:0] SPP_A_PWM_B_CTRL = 5'h0a;
  localparam logic [4:0] SPP_A_PWM_B_DUTY = 5'h0c;
  localparam logic [4:0] SPP_A_PWM_C_CTRL = 5'h11;
  localparam logic [4:0] SPP_A_PWM_C_DUTY = 5'h13;
  localparam logic [4:0] SPP_A_PWM_C_HIGH = 5'h14;
  localparam logic [4:0] SPP_A_TIMER_HIGH = 5'h15;
  localparam logic [4:0] SPP_A_POWER_CTRL = 5'h16;
  localparam logic [4:0] SPP_A_IR_CTRL = 5'h17;
  localparam logic [4:0] SPP_A_PWM_A_CTRL = 5'h18;
  localparam logic [4:0] SPP_A_PWM_A_DUTY = 5'h19;
  localparam logic [4:0] SPP_A_BUZZER_CTRL = 5'h1a;
  localparam logic [4:0] SPP_A_TIMER_SRC = 5'h1b;

  // field positions
  localparam int unsigned SPP_B_PORT_CHANGE = 1;
  localparam int unsigned SPP_B_GLOBAL_IRQ = 7;
  localparam int unsigned SPP_B_EXT_SEL = 4;
  localparam int unsigned SPP_B_IR_EN = 0;
  localparam int unsigned SPP_B_IR_POL = 2;
  localparam int unsigned SPP_B_OUT_EN = 7;
  localparam int unsigned SPP_B_ACT_LOW = 6;
  localparam int unsigned SPP_B_BUZ_EN = 7;
  localparam int unsigned SPP_B_UP_SRC = 5;
  localparam int unsigned SPP_B_UP_LOSC = 7;
  localparam int unsigned SPP_B_DN_SRC = 5;
  localparam int unsigned SPP_PL_LSB = 4;
  localparam int unsigned SPP_TH_B_LSB = 2;
  localparam int unsigned SPP_TH_A_LSB = 0;
  localparam int unsigned SPP_TH_R_LSB = 4;

  // reset values
  localparam logic [7:0] SPP_RST_ZERO = 8'h00;
  localparam logic [5:0] SPP_RST_DIR = 6'h3f;
  localparam logic [9:0] SPP_CNT_TOP = 10'h3ff;

  // pad control bundle for one pin
  typedef struct packed {
    logic drv_o;
    logic drv_oe;
    logic pull_hi;
    logic pull_lo;
  } spp_pad_t;

  typedef spp_pad_t [SPP_PINS-1:0] spp_pads_t;

endpackage : spp_pkg

// *** src/spp_port.sv ***
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - six pins, one data register reads/writes
// - per-pin direction bit selects output
// - pull-high on inputs per enable bit
// - pull-low only pins three to zero
// - open-drain output only pulls low
// - selected pin change sets change flag
// - change irq needs flag, enable, global
// - external irq select uses pin zero
// - external irq suppresses pin zero change
// - ir carrier enable drives pin one if third pwm off
// - pin three optional active-low reset input
// - instruction clock on pin four optionally
// - pin two clocks both timers externally
// - pin two optionally carries first pwm or buzzer
// - second pwm polarity bit, low when one
// - second pwm enable routes to pin zero
// - second pwm duty from timer-high bits
// - third pwm polarity bit, low when one
// - third pwm enable routes to pin one
// - third pwm duty own high field
// - first pwm enable routes to pin two if option set
// - ir polarity gates carrier with data
module spp_port
  import spp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [SPP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  // shared timer and sources
  input wire logic [9:0] down_count,
  input wire logic ir_carrier_in,
  input wire logic buzzer_in,
  input wire logic inst_clk_in,
  // configuration options and mode
  input wire logic cfg_ext_reset_en,
  input wire logic cfg_clk_out_en,
  input wire logic cfg_pin2_func_en,
  input wire logic mode_run_or_standby,
  // pads
  input wire logic [SPP_PINS-1:0] port_pins_i,
  output spp_pads_t pads_ff,
  // outputs to the core
  output logic port_irq_ff,
  output logic ext_irq_in_ff,
  output logic ext_reset_req_ff,
  output logic up_timer_clk_ff,
  output logic down_timer_clk_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_ff; // first stage
  logic rst_s2_ff; // released reset used below
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [5:0] port_data_reg_ff; // output latch
  logic [5:0] pin_direction_reg_ff; // 1 = input
  logic [5:0] pull_high_enable_reg_ff;
  logic [3:0] pull_low_enable_reg_ff; // bits 7:4 of the register
  logic [5:0] open_drain_select_reg_ff;
  logic [5:0] change_detect_select_reg_ff;
  logic [7:0] irq_enable_reg_ff;
  logic [7:0] irq_edge_reg_ff;
  logic [7:0] power_control_reg_one_ff;
  logic [7:0] ir_control_reg_ff;
  logic [7:0] pwm_a_control_ff;
  logic [7:0] pwm_a_duty_low_ff;
  logic [7:0] pwm_b_control_ff;
  logic [7:0] pwm_b_duty_low_ff;
  logic [7:0] pwm_c_control_ff;
  logic [7:0] pwm_c_duty_low_ff;
  logic [1:0] pwm_c_duty_high_ff;
  logic [7:0] timer_high_bits_reg_ff;
  logic [7:0] buzzer_control_reg_ff;
  logic [7:0] timer_src_reg_ff;
  logic port_change_flag_ff;

  // register writes
  always_ff @(posedge clk or negedge rst_s2_ff)
  begin
    if (!rst_s2_ff)
    begin
      port_data_reg_ff <= SPP_RST_ZERO[5:0];
      pin_direction_reg_ff <= SPP_RST_DIR;
      pull_high_enable_reg_ff <= SPP_RST_ZERO[5:0];
      pull_low_enable_reg_ff <= SPP_RST_ZERO[3:0];
      open_drain_select_reg_ff <= SPP_RST_ZERO[5:0];
      change_detect_select_reg_ff <= SPP_RST_ZERO[5:0];
      irq_enable_reg_ff <= SPP_RST_ZERO;
      irq_edge_reg_ff <= SPP_RST_ZERO;
      power_control_reg_one_ff <= SPP_RST_ZERO;
      ir_control_reg_ff <= SPP_RST_ZERO;
      pwm_a_control_ff <= SPP_RST_ZERO;
      pwm_a_duty_low_ff <= SPP_RST_ZERO;
      pwm_b_control_ff <= SPP_RST_ZERO;
      pwm_b_duty_low_ff <= SPP_RST_ZERO;
      pwm_c_control_ff <= SPP_RST_ZERO;
      pwm_c_duty_low_ff <= SPP_RST_ZERO;
      pwm_c_duty_high_ff <= SPP_RST_ZERO[1:0];
      timer_high_bits_reg_ff <= SPP_RST_ZERO;
      buzzer_control_reg_ff <= SPP_RST_ZERO;
      timer_src_reg_ff <= SPP_RST_ZERO;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        SPP_A_PORT_DATA: port_data_reg_ff <= reg_wdata[5:0];
        SPP_A_DIR: pin_direction_reg_ff <= reg_wdata[5:0];
        SPP_A_PULL_HIGH: pull_high_enable_reg_ff <= reg_wdata[5:0];
        SPP_A_PULL_LOW: pull_low_enable_reg_ff <= reg_wdata[7:SPP_PL_LSB];
        SPP_A_OPEN_DRAIN: open_drain_select_reg_ff <= reg_wdata[5:0];
        SPP_A_CHG_SEL: change_detect_select_reg_ff <= reg_wdata[5:0];
        SPP_A_IRQ_EN: irq_enable_reg_ff <= reg_wdata;
        SPP_A_IRQ_EDGE: irq_edge_reg_ff <= reg_wdata;
        SPP_A_POWER_CTRL: power_control_reg_one_ff <= reg_wdata;
        SPP_A_IR_CTRL: ir_control_reg_ff <= reg_wdata;
        SPP_A_PWM_A_CTRL: pwm_a_control_ff <= reg_wdata;
        SPP_A_PWM_A_DUTY: pwm_a_duty_low_ff <= reg_wdata;
        SPP_A_PWM_B_CTRL: pwm_b_control_ff <= reg_wdata;
        SPP_A_PWM_B_DUTY: pwm_b_duty_low_ff <= reg_wdata;
        SPP_A_PWM_C_CTRL: pwm_c_control_ff <= reg_wdata;
        SPP_A_PWM_C_DUTY: pwm_c_duty_low_ff <= reg_wdata;
        SPP_A_PWM_C_HIGH: pwm_c_duty_high_ff <= reg_wdata[1:0];
        SPP_A_TIMER_HIGH: timer_high_bits_reg_ff <= reg_wdata;
        SPP_A_BUZZER_CTRL: buzzer_control_reg_ff <= reg_wdata;
        SPP_A_TIMER_SRC: timer_src_reg_ff <= reg_wdata;
        default: ; // unmapped or read-only
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and change detection
  logic [5:0] pin_sync_ff; // first stage, read only by the next
  logic [5:0] pin_lvl_ff; // synchronised level
  logic [5:0] pin_prev_ff; // previous level
  logic pins_primed_ff; // previous level valid
  logic [5:0] chg_mask; // pins watched for change
  logic chg_event; // any watched pin changed

  // two-stage sampling of pad levels
  always_ff @(posedge clk or negedge rst_s2_ff)
  begin
    if (!rst_s2_ff)
    begin
      pin_sync_ff <= SPP_RST_ZERO[5:0];
      pin_lvl_ff <= SPP_RST_ZERO[5:0];
      pin_prev_ff <= SPP_RST_ZERO[5:0];
      pins_primed_ff <= 1'b0;
    end
    else
    begin
      pin_sync_ff <= port_pins_i;
      pin_lvl_ff <= pin_sync_ff;
      pin_prev_ff <= pin_lvl_ff;
      pins_primed_ff <= 1'b1;
    end
  end

  // external irq owns pin zero when selected
  always_comb
  begin
    chg_mask = change_detect_select_reg_ff;
    if (irq_edge_reg_ff[SPP_B_EXT_SEL])
    begin
      chg_mask[0] = 1'b0;
    end
  end

  assign chg_event = pins_primed_ff && |((pin_lvl_ff ^ pin_prev_ff) & chg_mask);

  // sticky change flag; a set beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_s2_ff)
  begin
    if (!rst_s2_ff)
    begin
      port_change_flag_ff <= 1'b0;
    end
    else if (chg_event)
    begin
      port_change_flag_ff <= 1'b1;
    end
    else if (reg_wr && reg_addr == SPP_A_IRQ_FLAG && !reg_wdata[SPP_B_PORT_CHANGE])
    begin
      port_change_flag_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm compare against the shared down-counter
  logic [9:0] duty_a; // first channel duty
  logic [9:0] duty_b; // second channel duty
  logic [9:0] duty_c; // third channel duty
  logic pwm_a_wave;
  logic pwm_b_wave;
  logic pwm_c_wave;

  assign duty_a = {timer_high_bits_reg_ff[SPP_TH_A_LSB +: 2], pwm_a_duty_low_ff};
  assign duty_b = {timer_high_bits_reg_ff[SPP_TH_B_LSB +: 2], pwm_b_duty_low_ff};
  assign duty_c = {pwm_c_duty_high_ff, pwm_c_duty_low_ff};

  // active while counter at or below duty, then polarity
  assign pwm_a_wave = (down_count <= duty_a) ^ pwm_a_control_ff[SPP_B_ACT_LOW];
  assign pwm_b_wave = (down_count <= duty_b) ^ pwm_b_control_ff[SPP_B_ACT_LOW];
  assign pwm_c_wave = (down_count <= duty_c) ^ pwm_c_control_ff[SPP_B_ACT_LOW];

  ////////////////////////////////////////////////////////////////////////////
  // pad drive: special functions override the latch
  logic [5:0] sf_en; // special function owns the pin
  logic [5:0] sf_dat; // special function level
  logic ir_gated; // carrier gated by latch data
  logic pin2_pwm;
  logic pin2_buz;
  spp_pads_t nxt_pads;

  assign ir_gated = ir_carrier_in &
    (port_data_reg_ff[1] ^ ir_control_reg_ff[SPP_B_IR_POL]);
  assign pin2_pwm = pwm_a_control_ff[SPP_B_OUT_EN] & cfg_pin2_func_en;
  assign pin2_buz = buzzer_control_reg_ff[SPP_B_BUZ_EN] & cfg_pin2_func_en;

  // special function select per pin
  always_comb
  begin
    sf_en = 6'h00;
    sf_dat = 6'h00;
    sf_en[0] = pwm_b_control_ff[SPP_B_OUT_EN];
    sf_dat[0] = pwm_b_wave;
    if (pwm_c_control_ff[SPP_B_OUT_EN])
    begin
      sf_en[1] = 1'b1;
      sf_dat[1] = pwm_c_wave;
    end
    else if (ir_control_reg_ff[SPP_B_IR_EN])
    begin
      sf_en[1] = 1'b1;
      sf_dat[1] = ir_gated;
    end
    sf_en[2] = pin2_pwm | pin2_buz;
    sf_dat[2] = pin2_pwm ? pwm_a_wave : buzzer_in;
    sf_en[4] = cfg_clk_out_en & mode_run_or_standby;
    sf_dat[4] = inst_clk_in;
  end

  // one generate entry per pin
  for (genvar gi = 0; gi < SPP_PINS; gi++)
  begin : g_pad
    logic is_out; // pin drives
    logic lvl; // level to drive
    logic ext_rst_pin; // pin held as reset input
    assign ext_rst_pin = (gi == 3) && cfg_ext_reset_en;
    assign is_out = !ext_rst_pin && (sf_en[gi] || !pin_direction_reg_ff[gi]);
    assign lvl = sf_en[gi] ? sf_dat[gi] : port_data_reg_ff[gi];
    always_comb
    begin
      nxt_pads[gi].drv_o = lvl;
      // open drain drives only when low
      nxt_pads[gi].drv_oe = is_out && !(open_drain_select_reg_ff[gi] && lvl);
      nxt_pads[gi].pull_hi = !is_out && pull_high_enable_reg_ff[gi];
      if (gi < SPP_PL_PINS)
      begin
        // index folded so the upper pins never select past the field
        nxt_pads[gi].pull_lo = !is_out && pull_low_enable_reg_ff[gi % SPP_PL_PINS];
      end
      else
      begin
        nxt_pads[gi].pull_lo = 1'b0;
      end
    end
  end

  // registered pad controls
  always_ff @(posedge clk or negedge rst_s2_ff)
  begin
    if (!rst_s2_ff)
    begin
      pads_ff <= '0;
    end
    else
    begin
      pads_ff <= nxt_pads;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core-facing signals
  always_ff @(posedge clk or negedge rst_s2_ff)
  begin
    if (!rst_s2_ff)
    begin
      port_irq_ff <= 1'b0;
      ext_irq_in_ff <= 1'b0;
      ext_reset_req_ff <= 1'b0;
      up_timer_clk_ff <= 1'b0;
      down_timer_clk_ff <= 1'b0;
    end
    else
    begin
      port_irq_ff <= port_change_flag_ff & irq_enable_reg_ff[SPP_B_PORT_CHANGE] &
        power_control_reg_one_ff[SPP_B_GLOBAL_IRQ];
      ext_irq_in_ff <= irq_edge_reg_ff[SPP_B_EXT_SEL] & pin_lvl_ff[0];
      ext_reset_req_ff <= cfg_ext_reset_en & !pin_lvl_ff[3];
      up_timer_clk_ff <= timer_src_reg_ff[SPP_B_UP_SRC] &
        !timer_src_reg_ff[SPP_B_UP_LOSC] & pin_lvl_ff[2];
      down_timer_clk_ff <= timer_src_reg_ff[SPP_B_DN_SRC] & pin_lvl_ff[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid the cycle after the strobe
  logic [7:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = SPP_RST_ZERO;
    unique case (reg_addr)
      SPP_A_PORT_DATA: nxt_rdata = {2'b00, pin_lvl_ff};
      SPP_A_DIR: nxt_rdata = {2'b00, pin_direction_reg_ff};
      SPP_A_PULL_HIGH: nxt_rdata = {2'b00, pull_high_enable_reg_ff};
      SPP_A_PULL_LOW: nxt_rdata = {pull_low_enable_reg_ff, 4'h0};
      SPP_A_OPEN_DRAIN: nxt_rdata = {2'b00, open_drain_select_reg_ff};
      SPP_A_CHG_SEL: nxt_rdata = {2'b00, change_detect_select_reg_ff};
      SPP_A_IRQ_FLAG: nxt_rdata[SPP_B_PORT_CHANGE] = port_change_flag_ff;
      SPP_A_IRQ_EN: nxt_rdata = irq_enable_reg_ff;
      SPP_A_IRQ_EDGE: nxt_rdata = irq_edge_reg_ff;
      SPP_A_POWER_CTRL: nxt_rdata = power_control_reg_one_ff;
      SPP_A_TIMER_HIGH: nxt_rdata = timer_high_bits_reg_ff;
      SPP_A_TIMER_SRC: nxt_rdata = timer_src_reg_ff;
      default: nxt_rdata = SPP_RST_ZERO; // write-only or unmapped
    endcase
  end

  always_ff @(posedge clk or negedge rst_s2_ff)
  begin
    if (!rst_s2_ff)
    begin
      reg_rdata_ff <= SPP_RST_ZERO;
    end
    else if (reg_rd)
    begin
      reg_rdata_ff <= nxt_rdata;
    end
    else
    begin
      reg_rdata_ff <= SPP_RST_ZERO;
    end
  end

endmodule : spp_port

// *** tb/spp_board_model.sv ***
`timescale 1ns/100ps
module spp_board_model
  import spp_pkg::*;
(
  // clock
  input wire logic clk,
  // pad controls from the port
  input wire spp_pads_t pads_ff,
  // board resistors and external drivers
  input wire logic [5:0] board_pu,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  // resolved pin levels
  output logic [5:0] pin_level
);
  logic float_q = 1'b0; // flips every cycle so a floating pin never holds a level
  //////////////////////////////////////////////////////////////////////////////
  // floating pattern
  always @(posedge clk) float_q <= ~float_q;
  // strongest source wins: port drive, board driver, pulls, then float
  always_comb
  begin
    for (int k = 0; k < 6; k++)
    begin
      if (pads_ff[k].drv_oe)
        pin_level[k] = pads_ff[k].drv_o;
      else if (ext_en[k])
        pin_level[k] = ext_val[k];
      else if (pads_ff[k].pull_hi || board_pu[k])
        pin_level[k] = 1'b1;
      else if (pads_ff[k].pull_lo)
        pin_level[k] = 1'b0;
      else
        pin_level[k] = float_q;
    end
  end
endmodule : spp_board_model

// *** tb/spp_port_monitor.sv ***
`timescale 1ns/100ps
module spp_port_monitor
  import spp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register read side
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  // options and pins
  input wire logic cfg_ext_reset_en,
  input wire logic cfg_clk_out_en,
  input wire logic mode_run_or_standby,
  input wire logic [SPP_PINS-1:0] port_pins_i,
  input wire spp_pads_t pads_ff,
  // core-side outputs
  input wire logic ext_irq_in_ff,
  input wire logic ext_reset_req_ff,
  input wire logic up_timer_clk_ff,
  input wire logic down_timer_clk_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // reset pin held low with the option on
  sequence s_rst_low;
    (cfg_ext_reset_en && !port_pins_i[3])[*6];
  endsequence
  // reset pin idle or option off
  sequence s_rst_idle;
    (!cfg_ext_reset_en || port_pins_i[3])[*6];
  endsequence
  // clock output requested in a running mode
  sequence s_clk_out;
    (cfg_clk_out_en && mode_run_or_standby)[*3];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
    else $error("read data not zero outside a read");
  upper_pull_a: assert property (!pads_ff[4].pull_lo && !pads_ff[5].pull_lo)
    else $error("pull low on an upper pin");
  rst_assert_a: assert property (s_rst_low |-> ext_reset_req_ff)
    else $error("reset request missing");
  rst_release_a: assert property (s_rst_idle |-> !ext_reset_req_ff)
    else $error("reset request without cause");
  rst_pin_a: assert property (cfg_ext_reset_en [*3] |-> !pads_ff[3].drv_oe)
    else $error("reset pin driven");
  clk_out_a: assert property (s_clk_out |-> pads_ff[4].drv_oe)
    else $error("clock output not driven");
  up_clk_a: assert property ($rose(up_timer_clk_ff) |-> $past(port_pins_i[2]) ||
    $past(port_pins_i[2], 2) || $past(port_pins_i[2], 3) || $past(port_pins_i[2], 4))
    else $error("up timer clock without pin edge");
  down_clk_a: assert property ($rose(down_timer_clk_ff) |-> $past(port_pins_i[2]) ||
    $past(port_pins_i[2], 2) || $past(port_pins_i[2], 3) || $past(port_pins_i[2], 4))
    else $error("down timer clock without pin edge");
  ext_irq_a: assert property ($rose(ext_irq_in_ff) |-> $past(port_pins_i[0]) ||
    $past(port_pins_i[0], 2) || $past(port_pins_i[0], 3) || $past(port_pins_i[0], 4))
    else $error("external irq input without pin edge");
endmodule : spp_port_monitor

bind spp_port spp_port_monitor i_spp_port_monitor (.clk(clk), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .cfg_ext_reset_en(cfg_ext_reset_en),
  .cfg_clk_out_en(cfg_clk_out_en), .mode_run_or_standby(mode_run_or_standby),
  .port_pins_i(port_pins_i), .pads_ff(pads_ff), .ext_irq_in_ff(ext_irq_in_ff),
  .ext_reset_req_ff(ext_reset_req_ff), .up_timer_clk_ff(up_timer_clk_ff),
  .down_timer_clk_ff(down_timer_clk_ff));

// *** tb/tb.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb
  import spp_pkg::*;
;
  typedef struct {logic [5:0] dir, od, dat, ph; logic [7:0] pl; logic [5:0] pu, rd;} spp_row_t;
  logic clk = 1'b0, rst_n, reg_wr, reg_rd;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_ff;
  logic [9:0] down_count;
  logic ir_carrier_in, buzzer_in, inst_clk_in = 1'b0, cfg_ext_reset_en, cfg_clk_out_en;
  logic cfg_pin2_func_en, mode_run_or_standby, port_irq_ff, ext_irq_in_ff;
  logic ext_reset_req_ff, up_timer_clk_ff, down_timer_clk_ff;
  logic [5:0] port_pins_i, board_pu, ext_en, ext_val;
  spp_pads_t pads_ff;
  int num_errors = 0, comparisons = 0;
  // pad rows: direction, open drain, data, pulls, board pull-up, pin read
  spp_row_t rows [7] = '{'{6'h3f, 6'h00, 6'h00, 6'h3f, 8'h00, 6'h00, 6'h3f},
    '{6'h3f, 6'h00, 6'h00, 6'h30, 8'hf0, 6'h00, 6'h30},
    '{6'h00, 6'h00, 6'h2a, 6'h00, 8'h00, 6'h00, 6'h2a},
    '{6'h00, 6'h3f, 6'h15, 6'h00, 8'h00, 6'h3f, 6'h15},
    '{6'h0f, 6'h00, 6'h10, 6'h0f, 8'h00, 6'h00, 6'h1f},
    '{6'h2a, 6'h00, 6'h00, 6'h2a, 8'h00, 6'h00, 6'h2a},
    '{6'h3f, 6'h00, 6'h00, 6'h00, 8'hf0, 6'h30, 6'h30}};
  // pwm channels a, b, c: control, duty, pin, full duty value
  logic [4:0] pc_ctrl [3] = '{SPP_A_PWM_A_CTRL, SPP_A_PWM_B_CTRL, SPP_A_PWM_C_CTRL};
  logic [4:0] pc_duty [3] = '{SPP_A_PWM_A_DUTY, SPP_A_PWM_B_DUTY, SPP_A_PWM_C_DUTY};
  int pc_pin [3] = '{2, 0, 1};
  logic [9:0] pc_val [3] = '{10'h380, 10'h180, 10'h280};
  //////////////////////////////////////////////////////////////////////////////
  spp_port i_spp_port (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .down_count(down_count), .ir_carrier_in(ir_carrier_in), .buzzer_in(buzzer_in),
    .inst_clk_in(inst_clk_in), .cfg_ext_reset_en(cfg_ext_reset_en),
    .cfg_clk_out_en(cfg_clk_out_en), .cfg_pin2_func_en(cfg_pin2_func_en),
    .mode_run_or_standby(mode_run_or_standby), .port_pins_i(port_pins_i),
    .pads_ff(pads_ff), .port_irq_ff(port_irq_ff), .ext_irq_in_ff(ext_irq_in_ff),
    .ext_reset_req_ff(ext_reset_req_ff), .up_timer_clk_ff(up_timer_clk_ff),
    .down_timer_clk_ff(down_timer_clk_ff));
  spp_board_model i_spp_board_model (.clk(clk), .pads_ff(pads_ff), .board_pu(board_pu),
    .ext_en(ext_en), .ext_val(ext_val), .pin_level(port_pins_i));
  //////////////////////////////////////////////////////////////////////////////
  // clock and instruction clock source
  always #2 clk = ~clk;
  always @(posedge clk) inst_clk_in <= ~inst_clk_in;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one-cycle register write
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // one-cycle register read, data checked in the following cycle
  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] ex,
    input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata_ff & m)
  endtask : rd
  // gathers one pad field over all pins
  function automatic logic [5:0] pf(input int f);
    for (int k = 0; k < 6; k++)
      pf[k] = pads_ff[k][f];
  endfunction : pf
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("Error watchdog expired");
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, ir_carrier_in, buzzer_in} = '0;
    {cfg_ext_reset_en, cfg_clk_out_en, cfg_pin2_func_en} = '0;
    {mode_run_or_standby, board_pu, ext_en, ext_val} = '0;
    down_count = 10'h3ff;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    rd(SPP_A_DIR, 8'h3f, 8'h3f, "dir reset");
    rd(SPP_A_PWM_B_CTRL, 8'hff, 8'h00, "write only read");
    wr(5'h1f, 8'hff);
    rd(5'h1f, 8'hff, 8'h00, "unmapped read");
    rd(SPP_A_DIR, 8'h3f, 8'h3f, "unmapped write");
    `CHK("pin0 idle", 1'b0, pads_ff[0].drv_oe)
    done("reset");
    foreach (rows[i])
    begin
      board_pu <= rows[i].pu;
      wr(SPP_A_DIR, {2'b00, rows[i].dir});
      wr(SPP_A_OPEN_DRAIN, {2'b00, rows[i].od});
      wr(SPP_A_PULL_HIGH, {2'b00, rows[i].ph});
      wr(SPP_A_PULL_LOW, rows[i].pl);
      wr(SPP_A_PORT_DATA, {2'b00, rows[i].dat});
      tick(4);
      `CHK("pad enable", ~rows[i].dir & ~(rows[i].od & rows[i].dat), pf(2))
      `CHK("pad drive", rows[i].dat & ~rows[i].dir & ~rows[i].od, pf(3) & ~rows[i].dir & ~rows[i].od)
      `CHK("pull high", rows[i].ph & rows[i].dir, pf(1) & rows[i].dir)
      `CHK("pull low", {2'b00, rows[i].pl[7:4]} & rows[i].dir, pf(0) & rows[i].dir)
      rd(SPP_A_PORT_DATA, 8'h3f, {2'b00, rows[i].rd}, "pin read");
    end
    done("pad rows");
    board_pu <= 6'h00;
    ext_en <= 6'h3f;
    wr(SPP_A_PULL_HIGH, 8'h00);
    wr(SPP_A_PULL_LOW, 8'h00);
    wr(SPP_A_CHG_SEL, 8'h3f);
    wr(SPP_A_IRQ_EN, 8'h02);
    wr(SPP_A_POWER_CTRL, 8'h80);
    tick(6);
    wr(SPP_A_IRQ_FLAG, 8'h00);
    tick(2);
    rd(SPP_A_IRQ_FLAG, 8'h02, 8'h00, "flag clear");
    `CHK("irq idle", 1'b0, port_irq_ff)
    ext_val <= 6'h04;
    tick(6);
    rd(SPP_A_IRQ_FLAG, 8'h02, 8'h02, "flag set");
    `CHK("irq raised", 1'b1, port_irq_ff)
    tick(20);
    rd(SPP_A_IRQ_FLAG, 8'h02, 8'h02, "flag held");
    wr(SPP_A_IRQ_FLAG, 8'h00);
    tick(3);
    `CHK("irq cleared", 1'b0, port_irq_ff)
    wr(SPP_A_POWER_CTRL, 8'h00);
    ext_val <= 6'h00;
    tick(6);
    rd(SPP_A_IRQ_FLAG, 8'h02, 8'h02, "flag again");
    `CHK("irq masked", 1'b0, port_irq_ff)
    wr(SPP_A_IRQ_EDGE, 8'h10);
    wr(SPP_A_CHG_SEL, 8'h03);
    wr(SPP_A_IRQ_FLAG, 8'h00);
    ext_val <= 6'h05;
    tick(6);
    rd(SPP_A_IRQ_FLAG, 8'h02, 8'h00, "pin0 suppressed");
    `CHK("ext irq input", 1'b1, ext_irq_in_ff)
    ext_val <= 6'h07;
    tick(6);
    rd(SPP_A_IRQ_FLAG, 8'h02, 8'h02, "pin1 change");
    wr(SPP_A_IRQ_EDGE, 8'h00);
    ext_en <= 6'h00;
    done("change detect");
    cfg_pin2_func_en <= 1'b1;
    wr(SPP_A_DIR, 8'h00);
    wr(SPP_A_PORT_DATA, 8'h00);
    wr(SPP_A_TIMER_HIGH, 8'h07);
    wr(SPP_A_PWM_C_HIGH, 8'h02);
    for (int c = 0; c < 3; c++)
    begin
      wr(pc_duty[c], 8'h80);
      for (int p = 0; p < 2; p++)
      begin
        wr(pc_ctrl[c], {1'b1, p[0], 6'h00});
        down_count <= pc_val[c];
        tick(3);
        `CHK("pwm at duty", ~p[0], pads_ff[pc_pin[c]].drv_o)
        @(posedge clk) down_count <= pc_val[c] + 10'h001;
        tick(3);
        `CHK("pwm past duty", p[0], pads_ff[pc_pin[c]].drv_o)
      end
      wr(pc_ctrl[c], 8'h00);
      tick(3);
      `CHK("pwm released", 1'b0, pads_ff[pc_pin[c]].drv_o)
    end
    wr(SPP_A_BUZZER_CTRL, 8'h80);
    buzzer_in <= 1'b1;
    tick(3);
    `CHK("buzzer on pin2", 1'b1, pads_ff[2].drv_o)
    @(posedge clk) cfg_pin2_func_en <= 1'b0;
    tick(3);
    `CHK("pin2 option off", 1'b0, pads_ff[2].drv_o)
    @(posedge clk) ir_carrier_in <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(SPP_A_PORT_DATA, {6'h00, i[0], 1'b0});
      wr(SPP_A_IR_CTRL, {5'h00, i[1], 2'b01});
      tick(3);
      `CHK("ir gate", i[1] ^ i[0], pads_ff[1].drv_o)
    end
    wr(SPP_A_PORT_DATA, 8'h00);
    ir_carrier_in <= 1'b0;
    tick(3);
    `CHK("ir carrier low", 1'b0, pads_ff[1].drv_o)
    done("pin functions");
    wr(SPP_A_DIR, 8'h3f);
    ext_en <= 6'h0c;
    ext_val <= 6'h08;
    wr(SPP_A_TIMER_SRC, 8'h20);
    ext_val <= 6'h0c;
    tick(5);
    `CHK("up timer clock", 1'b1, up_timer_clk_ff)
    `CHK("down timer clock", 1'b1, down_timer_clk_ff)
    wr(SPP_A_TIMER_SRC, 8'ha0);
    tick(3);
    `CHK("up timer low osc", 1'b0, up_timer_clk_ff)
    `CHK("down timer kept", 1'b1, down_timer_clk_ff)
    @(posedge clk) cfg_ext_reset_en <= 1'b1;
    ext_val <= 6'h04;
    tick(8);
    `CHK("reset request", 1'b1, ext_reset_req_ff)
    ext_val <= 6'h0c;
    tick(8);
    `CHK("reset released", 1'b0, ext_reset_req_ff)
    @(posedge clk) cfg_ext_reset_en <= 1'b0;
    cfg_clk_out_en <= 1'b1;
    mode_run_or_standby <= 1'b1;
    tick(4);
    `CHK("clock out", 1'b1, pads_ff[4].drv_oe)
    @(posedge clk) mode_run_or_standby <= 1'b0;
    tick(4);
    `CHK("clock out halted", 1'b0, pads_ff[4].drv_oe)
    done("clocks and reset pin");
    wr(SPP_A_DIR, 8'h00);
    rst_n <= 1'b0;
    tick(2);
    `CHK("irq in reset", 1'b0, port_irq_ff)
    @(posedge clk) rst_n <= 1'b1;
    tick(3);
    rd(SPP_A_DIR, 8'h3f, 8'h3f, "dir after reset");
    done("second reset");
    print_verdict();
  end
endmodule : tb
